// File: logic/ult_pkg.sv
/*
 * Shared constants for the legacy trap configuration block: register offsets,
 * field positions, reset values and the gate pass-through command bytes.
 * Assumes a single core clock domain and the config and legacy I/O paths on it.
 */
package ult_pkg;

    localparam int ULT_FUNCS = 4;

    // Configuration offsets
    localparam logic [7:0] ULT_OFS_PIN_CODE = 8'h3D;
    localparam logic [7:0] ULT_OFS_RELEASE = 8'h60;
    localparam logic [7:0] ULT_OFS_LEGACY = 8'hC0;

    // Fixed read values and the legacy control reset value
    localparam logic [2:0] ULT_PIN_F0 = 3'h1;
    localparam logic [2:0] ULT_PIN_F1 = 3'h2;
    localparam logic [2:0] ULT_PIN_F2 = 3'h3;
    localparam logic [2:0] ULT_PIN_F3 = 3'h1;
    localparam logic [7:0] ULT_RELEASE_NUMBER = 8'h10;
    localparam logic [15:0] ULT_LEGACY_RESET = 16'h2000;

    // Legacy control field positions
    localparam int ULT_B_END_STATUS = 15;
    localparam int ULT_B_PCI_IRQ_EN = 13;
    localparam int ULT_B_CTRL_IRQ_STATUS = 12;
    localparam int ULT_B_CMD_WR_STATUS = 11;
    localparam int ULT_B_CMD_RD_STATUS = 10;
    localparam int ULT_B_DATA_WR_STATUS = 9;
    localparam int ULT_B_DATA_RD_STATUS = 8;
    localparam int ULT_B_END_SMI_EN = 7;
    localparam int ULT_B_PASS_STATE = 6;
    localparam int ULT_B_GATE_PASS_EN = 5;
    localparam int ULT_B_CTRL_IRQ_SMI_EN = 4;

    // Gate pass-through command bytes on the command port
    localparam logic [7:0] ULT_GATE_CMD_WRITE = 8'hD1;
    localparam logic [7:0] ULT_GATE_CMD_END = 8'hFF;

    typedef enum logic [1:0] {
        ULT_SEQ_IDLE = 2'b00,
        ULT_SEQ_CMD = 2'b01,
        ULT_SEQ_DATA = 2'b10
    } ult_seq_t;

endpackage

// File: logic/ult_trap_if.sv
/*
 * Carrier between the trap core and the gate pass-through sequencer.
 * Assumes both ends sit on the same core clock.
 */
`timescale 1ns/100ps

interface ult_trap_if;
    logic ioStrobe;
    logic ioWrite;
    logic ioCmdPort;
    logic [7:0] ioData;
    logic passEnable;
    logic suppress;
    logic endEvent;
    logic seqActive;

    modport core (
        output ioStrobe,
        output ioWrite,
        output ioCmdPort,
        output ioData,
        output passEnable,
        input suppress,
        input endEvent,
        input seqActive
    );

    modport seq (
        input ioStrobe,
        input ioWrite,
        input ioCmdPort,
        input ioData,
        input passEnable,
        output suppress,
        output endEvent,
        output seqActive
    );
endinterface

// File: logic/ult_gate_seq.sv
/*
 * Gate pass-through sequencer: recognises command write D1h, data write, then
 * command write FFh, and marks those writes so that they do not trap.
 * Assumes one legacy access per strobe cycle on the core clock.
 */
`timescale 1ns/100ps

module ult_gate_seq
    import ult_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    ult_trap_if.seq trap
);
    ult_seq_t state;
    ult_seq_t next_state;
    logic isWrite;

    assign isWrite = trap.ioStrobe && trap.ioWrite;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        trap.suppress = 1'b0;
        trap.endEvent = 1'b0;
        if (!trap.passEnable) begin
            next_state = ULT_SEQ_IDLE;
        end else if (trap.ioStrobe) begin
            case (state)
                ULT_SEQ_IDLE: begin
                    if (isWrite && trap.ioCmdPort && trap.ioData == ULT_GATE_CMD_WRITE) begin
                        next_state = ULT_SEQ_CMD;
                        trap.suppress = 1'b1;
                    end
                end
                ULT_SEQ_CMD: begin
                    if (isWrite && !trap.ioCmdPort) begin
                        next_state = ULT_SEQ_DATA;
                        trap.suppress = 1'b1;
                    end else begin
                        next_state = ULT_SEQ_IDLE;
                    end
                end
                ULT_SEQ_DATA: begin
                    next_state = ULT_SEQ_IDLE;
                    if (isWrite && trap.ioCmdPort && trap.ioData == ULT_GATE_CMD_END) begin
                        trap.suppress = 1'b1;
                        trap.endEvent = 1'b1;
                    end
                end
                default: next_state = ULT_SEQ_IDLE;
            endcase
        end
    end

    assign trap.seqActive = (state != ULT_SEQ_IDLE);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ULT_SEQ_IDLE;
        end else begin
            state <= next_state;
        end
    end
endmodule

// File: logic/ult_legacy_trap.sv
/*
 * Legacy keyboard/mouse trap and identity registers for four classic host
 * controller functions, reached over a simple configuration access port.
 * Assumes config and legacy I/O requests are single-cycle strobes on ref_clk.
 */
//
// Contract
// - Interrupt pin code reads 1,2,3,1 for functions 0-3; upper bits zero.
// - Function interrupts route to lines A, D, C, A respectively.
// - Bus release number register reads constant 10h.
// - Control per function; enables ORed, trap status shared by all; bits 4 and 13 are kept per function, not ORed.
// - End of pass-through sets bit 15 regardless of bit 7.
// - Writing 1 clears a status bit from any function; 0 leaves it.
// - Bit 13 resets to 1; when 0 the PCI interrupt is suppressed.
// - Bit 12 shows this controller's raw interrupt before bit 13 gating.
// - Writes to bit 12 are ignored; cleared at the interrupt source.
// - Command port write sets bit 11 regardless of bit 3.
// - Command port read sets bit 10 regardless of bit 2.
// - Data port write sets bit 9 regardless of bit 1.
// - Data port read sets bit 8 regardless of bit 0.
// - Writes of a recognised gate pass-through sequence do not set trap status.
// - Bit 4 set makes this controller's interrupt raise SMI.
// - The gate pass-through sequence is recognised only with bit 5 set.
// - Bit 7 set makes the end of pass-through raise SMI.
`timescale 1ns/100ps

module ult_legacy_trap
    import ult_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic cfgRead,
    input wire logic cfgWrite,
    input wire logic [1:0] cfgFunc,
    input wire logic [7:0] cfgAddr,
    input wire logic [1:0] cfgByteEn,
    input wire logic [15:0] cfgWdata,
    output logic [15:0] cfgRdata,
    output logic cfgRvalid,
    input wire logic ioStrobe,
    input wire logic ioWrite,
    input wire logic ioCmdPort,
    input wire logic [7:0] ioData,
    input wire logic [3:0] ctrlIrq,
    output logic irq_route_a,
    output logic irq_route_c,
    output logic irq_route_d,
    output logic smiOut
);
    ult_trap_if trap ();

    // Per-function low byte (bit 6 is not stored) and bit 13
    logic [7:0] ctlLow [ULT_FUNCS];
    logic [7:0] next_ctlLow [ULT_FUNCS];
    logic [ULT_FUNCS-1:0] pciIrqEn;
    logic [ULT_FUNCS-1:0] next_pciIrqEn;
    // Shared status: 15, 11, 10, 9, 8
    logic [4:0] shared;
    logic [4:0] next_shared;
    logic [7:0] enOr;
    logic legacyWrite;
    logic [15:0] legacyWord [ULT_FUNCS];
    logic [15:0] next_cfgRdata;
    logic next_cfgRvalid;
    logic next_routeA;
    logic next_routeC;
    logic next_routeD;
    logic next_smi;
    logic smiPortTrap;
    logic smiEndPass;
    logic smiCtrlIrq;
    logic [ULT_FUNCS-1:0] gatedIrq;
    logic [ULT_FUNCS-1:0] ctrlSmi;

    // Writes to any other offset fall away: identity registers are read-only
    assign legacyWrite = cfgWrite && cfgAddr == ULT_OFS_LEGACY;

    assign trap.ioStrobe = ioStrobe;
    assign trap.ioWrite = ioWrite;
    assign trap.ioCmdPort = ioCmdPort;
    assign trap.ioData = ioData;
    assign trap.passEnable = enOr[ULT_B_GATE_PASS_EN];

    // One sequencer serves all functions, armed by bit 5 of any of them
    ult_gate_seq u_seq (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .trap(trap.seq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Per-function control
    genvar f;
    generate
        for (f = 0; f < ULT_FUNCS; f++) begin : g_func
            always_comb begin
                next_ctlLow[f] = ctlLow[f];
                next_pciIrqEn[f] = pciIrqEn[f];
                if (legacyWrite && cfgFunc == 2'(f)) begin
                    if (cfgByteEn[0]) begin
                        next_ctlLow[f] = cfgWdata[7:0] & 8'hBF;
                    end
                    if (cfgByteEn[1]) begin
                        next_pciIrqEn[f] = cfgWdata[ULT_B_PCI_IRQ_EN];
                    end
                end
            end

            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    ctlLow[f] <= ULT_LEGACY_RESET[7:0];
                    pciIrqEn[f] <= ULT_LEGACY_RESET[ULT_B_PCI_IRQ_EN];
                end else begin
                    ctlLow[f] <= next_ctlLow[f];
                    pciIrqEn[f] <= next_pciIrqEn[f];
                end
            end

            // Bit 12 is the raw interrupt; writes never reach it
            assign legacyWord[f] = {shared[4], 1'b0,
                pciIrqEn[f], ctrlIrq[f],
                shared[3:0], ctlLow[f][7],
                trap.seqActive, ctlLow[f][5:0]};
            // Bit 13 gates only the PCI line; the SMI path sees the raw level
            assign gatedIrq[f] = ctrlIrq[f] && pciIrqEn[f];
            assign ctrlSmi[f] = ctrlIrq[f] && ctlLow[f][ULT_B_CTRL_IRQ_SMI_EN];
        end
    endgenerate

    // Enables other than bits 4 and 13 act as one set: a bit set in any function arms the shared logic
    always_comb begin
        enOr = 8'h00;
        for (int i = 0; i < ULT_FUNCS; i++) begin
            enOr = enOr | ctlLow[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared trap status; a new event wins over a same-cycle clear, so an
    // access that lands while software clears is never lost
    // Reads see a new status bit from the cycle after its event edge
    logic [4:0] setEv;
    logic [4:0] clrEv;

    always_comb begin
        setEv = 5'h00;
        clrEv = 5'h00;
        setEv[4] = trap.endEvent;
        if (ioStrobe && !trap.suppress) begin
            setEv[3] = ioCmdPort && ioWrite;
            setEv[2] = ioCmdPort && !ioWrite;
            setEv[1] = !ioCmdPort && ioWrite;
            setEv[0] = !ioCmdPort && !ioWrite;
        end
        // Clear bits all sit in byte 1; a byte-0 write leaves the status alone
        if (legacyWrite && cfgByteEn[1]) begin
            clrEv = {cfgWdata[ULT_B_END_STATUS], cfgWdata[11:8]};
        end
        next_shared = (shared & ~clrEv) | setEv;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            shared <= 5'h00;
        end else begin
            shared <= next_shared;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Config reads, interrupt routing and SMI
    always_comb begin
        next_cfgRvalid = cfgRead;
        // Idle cycles and unmapped offsets return zero, never a stale word
        next_cfgRdata = 16'h0000;
        if (cfgRead) begin
            case (cfgAddr)
                ULT_OFS_PIN_CODE: begin
                    case (cfgFunc)
                        2'h0: next_cfgRdata = {13'h0000, ULT_PIN_F0};
                        2'h1: next_cfgRdata = {13'h0000, ULT_PIN_F1};
                        2'h2: next_cfgRdata = {13'h0000, ULT_PIN_F2};
                        default: next_cfgRdata = {13'h0000, ULT_PIN_F3};
                    endcase
                end
                ULT_OFS_RELEASE: next_cfgRdata = {8'h00, ULT_RELEASE_NUMBER};
                ULT_OFS_LEGACY: next_cfgRdata = legacyWord[cfgFunc];
                default: next_cfgRdata = 16'h0000;
            endcase
        end
        // Routing is fixed and independent of the reported pin code
        next_routeA = gatedIrq[0] || gatedIrq[3];
        next_routeC = gatedIrq[2];
        next_routeD = gatedIrq[1];
        // Port traps use the ORed enables, so a trap raises SMI through any
        // function whose enable is set
        smiPortTrap = |(shared[3:0] & enOr[3:0]);
        smiEndPass = shared[4] && enOr[ULT_B_END_SMI_EN];
        smiCtrlIrq = |ctrlSmi;
        // Level output: falls once every enabled pair is cleared
        next_smi = smiPortTrap || smiEndPass || smiCtrlIrq;
    end

    // All outputs leave flip-flops, so the far side never sees a glitch
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfgRdata <= 16'h0000;
            cfgRvalid <= 1'b0;
            irq_route_a <= 1'b0;
            irq_route_c <= 1'b0;
            irq_route_d <= 1'b0;
            smiOut <= 1'b0;
        end else begin
            cfgRdata <= next_cfgRdata;
            cfgRvalid <= next_cfgRvalid;
            irq_route_a <= next_routeA;
            irq_route_c <= next_routeC;
            irq_route_d <= next_routeD;
            smiOut <= next_smi;
        end
    end
endmodule

// File: test/ult_legacy_trap_chk.sv
/* Port assertions for the legacy trap block.
   Assumes one clock domain and binding onto ult_legacy_trap. */
`timescale 1ns/100ps

module ult_legacy_trap_chk
    import ult_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic cfgRead,
    input wire logic cfgWrite,
    input wire logic [1:0] cfgFunc,
    input wire logic [7:0] cfgAddr,
    input wire logic [15:0] cfgRdata,
    input wire logic cfgRvalid,
    input wire logic ioStrobe,
    input wire logic ioWrite,
    input wire logic ioCmdPort,
    input wire logic [3:0] ctrlIrq,
    input wire logic irq_route_a,
    input wire logic irq_route_c,
    input wire logic irq_route_d
);
    import ult_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////
    a_read_answer: assert property (cfgRead |=> cfgRvalid)
        else $error("read without answer");
    a_write_silent: assert property (cfgWrite |=> !cfgRvalid)
        else $error("write gave an answer");
    a_pin_upper: assert property (cfgRead && cfgAddr == ULT_OFS_PIN_CODE
        |=> cfgRdata[15:3] == 13'h0 && cfgRdata[2:0] != 3'h0) else $error("pin code bad");
    a_pin_func2: assert property (cfgRead && cfgAddr == 8'h3D && cfgFunc == 2'h2
        |=> cfgRdata == 16'h0003) else $error("pin code of function 2 bad");
    a_release_const: assert property (cfgRead && cfgAddr == ULT_OFS_RELEASE
        |=> cfgRdata == 16'h0010) else $error("release number bad");
    a_route_a: assert property (!ctrlIrq[0] && !ctrlIrq[3] |=> !irq_route_a)
        else $error("line A without its functions");
    a_route_c: assert property (!ctrlIrq[2] |=> !irq_route_c)
        else $error("line C without function 2");
    a_route_d: assert property (!ctrlIrq[1] |=> !irq_route_d)
        else $error("line D without function 1");
    a_cmd_read_trap: assert property (ioStrobe && !ioWrite && ioCmdPort ##1 !cfgWrite
        ##1 cfgRead && cfgAddr == ULT_OFS_LEGACY |=> cfgRdata[10])
        else $error("command read untrapped");
    a_data_read_trap: assert property (ioStrobe && !ioWrite && !ioCmdPort ##1 !cfgWrite
        ##1 cfgRead && cfgAddr == ULT_OFS_LEGACY |=> cfgRdata[8])
        else $error("data read untrapped");
    c_read: cover property (cfgRvalid);
    c_route_c: cover property ($rose(irq_route_c));
    c_write_trap: cover property (ioStrobe && ioWrite);
endmodule

bind ult_legacy_trap ult_legacy_trap_chk ult_legacy_trap_chk_i (.*);

// File: test/ult_host_model.sv
/* Host-side model: legacy port accesses and controller interrupt levels.
   Assumes the trap block samples its inputs on the rising edge. */
`timescale 1ns/100ps

module ult_host_model (
    input wire logic ref_clk,
    output logic ioStrobe,
    output logic ioWrite,
    output logic ioCmdPort,
    output logic [7:0] ioData,
    output logic [3:0] ctrlIrq
);
    initial begin
        ioStrobe = 1'b0;
        ioWrite = 1'b0;
        ioCmdPort = 1'b0;
        ioData = 8'h00;
        ctrlIrq = 4'h0;
    end

    task automatic io(input logic w, input logic cmd, input logic [7:0] d);
        @(posedge ref_clk);
        ioStrobe <= 1'b1;
        ioWrite <= w;
        ioCmdPort <= cmd;
        ioData <= d;
        @(posedge ref_clk);
        ioStrobe <= 1'b0;
        // Released bus must not keep showing the byte
        ioData <= ~d;
    endtask

    // Software clears the indication at the interrupt source only
    task automatic irq(input logic [3:0] v);
        @(posedge ref_clk);
        ctrlIrq <= v;
    endtask
endmodule

// File: test/tb_top.sv
/* Self-checking bench for the legacy trap block.
   Assumes the host model drives the legacy port and interrupt inputs. */
`timescale 1ns/100ps

module tb_top;
    import ult_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cfgRead = 1'b0, cfgWrite = 1'b0;
    logic [1:0] cfgFunc = 2'h0, cfgByteEn = 2'h0;
    logic [7:0] cfgAddr = 8'h00, ioData;
    logic [15:0] cfgWdata = 16'h0000, cfgRdata, expv;
    logic cfgRvalid, ioStrobe, ioWrite, ioCmdPort, irq_route_a, irq_route_c, irq_route_d, smiOut;
    logic [3:0] ctrlIrq;
    logic [2:0] pinExp [4] = '{ULT_PIN_F0, ULT_PIN_F1, ULT_PIN_F2, ULT_PIN_F3};
    logic [2:0] routeExp [4] = '{3'b100, 3'b001, 3'b010, 3'b100};
    int numErrors = 0, samplesChecked = 0, cycles = 0;

    ult_legacy_trap ult_legacy_trap_i (.*);
    ult_host_model ult_host_model_i (.*);

    initial forever #5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samplesChecked, numErrors);
        if (numErrors == 0 && samplesChecked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            numErrors++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            numErrors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [1:0] f, input logic [7:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        cfgRead <= 1'b1;
        cfgFunc <= f;
        cfgAddr <= a;
        @(posedge ref_clk);
        cfgRead <= 1'b0;
        #1;
        chk({15'h0, cfgRvalid}, 16'h0001);
        chk(cfgRdata, exp);
    endtask

    task automatic wr(input logic [1:0] f, input logic [7:0] a, input logic [1:0] be,
                      input logic [15:0] d);
        @(posedge ref_clk);
        cfgWrite <= 1'b1;
        cfgFunc <= f;
        cfgAddr <= a;
        cfgByteEn <= be;
        cfgWdata <= d;
        @(posedge ref_clk);
        cfgWrite <= 1'b0;
    endtask

    // SMI follows its cause one edge later; the check waits two edges
    task automatic smi(input logic e);
        repeat (2) @(posedge ref_clk);
        #1;
        chk({15'h0, smiOut}, {15'h0, e});
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        for (int f = 0; f < 4; f++) begin
            rd(2'(f), 8'h3D, {13'h0, pinExp[f]});
            rd(2'(f), 8'h60, 16'h0010);
            rd(2'(f), 8'hC0, 16'h2000);
        end
        wr(0, 8'h60, 2'b11, 16'hFFFF);
        rd(0, 8'h60, 16'h0010);
        rd(3, 8'h40, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            expv = 16'h2000 | (16'h0001 << (8 + k));
            ult_host_model_i.io(k[0], k[1], 8'h00);
            rd(2'(k), 8'hC0, expv);
            wr(2'(k + 1), 8'hC0, 2'b10, 16'h2000);
            rd(2'(k + 2), 8'hC0, expv);
            wr(2'(k + 3), 8'hC0, 2'b10, expv);
            rd(2'(k), 8'hC0, 16'h2000);
        end
        wr(2, 8'hC0, 2'b01, 16'h0008);
        ult_host_model_i.io(1'b1, 1'b1, 8'h00);
        smi(1'b1);
        rd(0, 8'hC0, 16'h2800);
        rd(2, 8'hC0, 16'h2808);
        wr(0, 8'hC0, 2'b10, 16'h2800);
        smi(1'b0);
        wr(2, 8'hC0, 2'b01, 16'h0000);
        wr(1, 8'hC0, 2'b01, 16'h0020);
        ult_host_model_i.io(1'b1, 1'b1, ULT_GATE_CMD_WRITE);
        rd(1, 8'hC0, 16'h2060);
        ult_host_model_i.io(1'b1, 1'b0, 8'h5A);
        ult_host_model_i.io(1'b1, 1'b1, ULT_GATE_CMD_END);
        rd(1, 8'hC0, 16'hA020);
        smi(1'b0);
        wr(3, 8'hC0, 2'b01, 16'h0080);
        smi(1'b1);
        wr(1, 8'hC0, 2'b11, 16'hA000);
        smi(1'b0);
        wr(3, 8'hC0, 2'b01, 16'h0000);
        ult_host_model_i.io(1'b1, 1'b1, ULT_GATE_CMD_WRITE);
        rd(0, 8'hC0, 16'h2800);
        wr(0, 8'hC0, 2'b10, 16'h2800);
        for (int k = 0; k < 4; k++) begin
            ult_host_model_i.irq(4'h1 << k);
            repeat (2) @(posedge ref_clk);
            #1;
            chk({13'h0, irq_route_a, irq_route_c, irq_route_d}, {13'h0, routeExp[k]});
        end
        ult_host_model_i.irq(4'h2);
        rd(1, 8'hC0, 16'h3000);
        rd(0, 8'hC0, 16'h2000);
        wr(1, 8'hC0, 2'b10, 16'h2000);
        rd(1, 8'hC0, 16'h3000);
        wr(1, 8'hC0, 2'b01, 16'h0010);
        smi(1'b1);
        wr(1, 8'hC0, 2'b10, 16'h0000);
        smi(1'b1);
        chk({15'h0, irq_route_d}, 16'h0000);
        rd(1, 8'hC0, 16'h1010);
        ult_host_model_i.irq(4'h0);
        smi(1'b0);
        tally_and_finish();
    end
endmodule
